// ==== logic/tpms_consts.svh ====
`ifndef TPMS_CONSTS_SVH
`define TPMS_CONSTS_SVH

// Synchroniser bit positions
`define TPMS_SYNC_W      5
`define TPMS_BIT_TCK     0
`define TPMS_BIT_TMS     1
`define TPMS_BIT_TDI     2
`define TPMS_BIT_TRST    3
`define TPMS_BIT_STRAP   4

// Instruction register
`define TPMS_IR_W        3
`define TPMS_IR_EXTEST   3'h0
`define TPMS_IR_IDCODE   3'h1
`define TPMS_IR_SAMPLE   3'h2
`define TPMS_IR_BYPASS   3'h7
`define TPMS_IR_CAPTURE  3'h1

// Identification register, value arbitrary
`define TPMS_ID_W        32
`define TPMS_IDCODE_DEF  32'h0000_0001

`endif

// ==== logic/tpms_pkg.sv ====
`default_nettype none
package tpms_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tpms_tap_t;
endpackage
`default_nettype wire

// ==== logic/tpms_sync_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface tpms_sync_if #(parameter int W = 5);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ==== logic/tpms_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpms_pin_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Pins
  input  wire logic [W-1:0] pinRaw,
  // Filtered levels and edges
  tpms_sync_if.src          syn
);
  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] rise_r;
  logic [W-1:0] fall_r;

  if (W < 1) begin
    $error("tpms_pin_sync: W must be positive");
  end

  // Three-stage chain
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
    end else begin
      ff1_r <= pinRaw;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // Level moves once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      level_r <= '0;
      rise_r  <= '0;
      fall_r  <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ff2_r[i] == ff3_r[i]) begin
          level_r[i] <= ff3_r[i];
          rise_r[i]  <= ff3_r[i] & ~level_r[i];
          fall_r[i]  <= ~ff3_r[i] & level_r[i];
        end else begin
          rise_r[i] <= 1'b0;
          fall_r[i] <= 1'b0;
        end
      end
    end
  end

  assign syn.level = level_r;
  assign syn.rise  = rise_r;
  assign syn.fall  = fall_r;
endmodule
`default_nettype wire

// ==== logic/tpms_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tpms_consts.svh"
module tpms_top #(
  parameter logic [`TPMS_ID_W-1:0] IDCODE = `TPMS_IDCODE_DEF
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Mode strap, with drive flag for the pull-up
  input  wire logic framerModeSelect,
  input  wire logic framerModeSelectDrv,
  // Test port pins
  input  wire logic testPortClock,
  input  wire logic testPortModeSel,
  input  wire logic testPortModeSelDrv,
  input  wire logic testPortDataIn,
  input  wire logic testPortResetN,
  output logic      testPortDataOut,
  output logic      testPortDataOutEn,
  // Mode and test enables
  output logic      legacyMode,
  output logic      globalTestPinEn,
  output logic      testCtrlBitHiEn,
  output logic      testCtrlBitLoEn
);
  tpms_sync_if #(.W(`TPMS_SYNC_W)) synIf ();

  logic [`TPMS_SYNC_W-1:0] rawPins;
  logic                    strapLvl;
  logic                    trstLvl;
  logic                    trstEffN;
  logic                    tckRise;
  logic                    tckFall;
  logic                    tmsLvl;
  logic                    tdiLvl;
  tpms_pkg::tpms_tap_t     state_r;
  logic [`TPMS_IR_W-1:0]   ir_r;
  logic [`TPMS_IR_W-1:0]   irShift_r;
  logic [`TPMS_ID_W-1:0]   drShift_r;
  logic                    tdo_r;
  logic                    tdoEn_r;
  logic                    legacy_r;
  logic                    testEn_r;

  // Pull-ups on mode strap and mode select
  always_comb begin
    rawPins = '0;
    rawPins[`TPMS_BIT_TCK]  = testPortClock;
    rawPins[`TPMS_BIT_TMS]  = testPortModeSelDrv ? testPortModeSel : 1'b1;
    rawPins[`TPMS_BIT_TDI]  = testPortDataIn;
    rawPins[`TPMS_BIT_TRST] = testPortResetN;
    // Strap enters inverted so a cleared chain reads legacy
    rawPins[`TPMS_BIT_STRAP] = ~(framerModeSelectDrv ? framerModeSelect : 1'b1);
  end

  tpms_pin_sync #(.W(`TPMS_SYNC_W)) uSync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinRaw  (rawPins),
    .syn     (synIf.src)
  );

  assign strapLvl = ~synIf.level[`TPMS_BIT_STRAP];
  assign trstLvl  = synIf.level[`TPMS_BIT_TRST];
  assign tckRise  = synIf.rise[`TPMS_BIT_TCK];
  assign tckFall  = synIf.fall[`TPMS_BIT_TCK];
  assign tmsLvl   = synIf.level[`TPMS_BIT_TMS];
  assign tdiLvl   = synIf.level[`TPMS_BIT_TDI];
  assign trstEffN = strapLvl ? 1'b0 : trstLvl;

  function automatic tpms_pkg::tpms_tap_t tapNext(input tpms_pkg::tpms_tap_t s,
                                                  input logic tms);
    unique case (s)
      tpms_pkg::TLR:    tapNext = tms ? tpms_pkg::TLR    : tpms_pkg::RTI;
      tpms_pkg::RTI:    tapNext = tms ? tpms_pkg::SEL_DR : tpms_pkg::RTI;
      tpms_pkg::SEL_DR: tapNext = tms ? tpms_pkg::SEL_IR : tpms_pkg::CAP_DR;
      tpms_pkg::CAP_DR: tapNext = tms ? tpms_pkg::EX1_DR : tpms_pkg::SH_DR;
      tpms_pkg::SH_DR:  tapNext = tms ? tpms_pkg::EX1_DR : tpms_pkg::SH_DR;
      tpms_pkg::EX1_DR: tapNext = tms ? tpms_pkg::UPD_DR : tpms_pkg::PA_DR;
      tpms_pkg::PA_DR:  tapNext = tms ? tpms_pkg::EX2_DR : tpms_pkg::PA_DR;
      tpms_pkg::EX2_DR: tapNext = tms ? tpms_pkg::UPD_DR : tpms_pkg::SH_DR;
      tpms_pkg::UPD_DR: tapNext = tms ? tpms_pkg::SEL_DR : tpms_pkg::RTI;
      tpms_pkg::SEL_IR: tapNext = tms ? tpms_pkg::TLR    : tpms_pkg::CAP_IR;
      tpms_pkg::CAP_IR: tapNext = tms ? tpms_pkg::EX1_IR : tpms_pkg::SH_IR;
      tpms_pkg::SH_IR:  tapNext = tms ? tpms_pkg::EX1_IR : tpms_pkg::SH_IR;
      tpms_pkg::EX1_IR: tapNext = tms ? tpms_pkg::UPD_IR : tpms_pkg::PA_IR;
      tpms_pkg::PA_IR:  tapNext = tms ? tpms_pkg::EX2_IR : tpms_pkg::PA_IR;
      tpms_pkg::EX2_IR: tapNext = tms ? tpms_pkg::UPD_IR : tpms_pkg::SH_IR;
      tpms_pkg::UPD_IR: tapNext = tms ? tpms_pkg::SEL_DR : tpms_pkg::RTI;
    endcase
  endfunction

  // Controller state
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !trstEffN) begin
      state_r <= tpms_pkg::TLR;
    end else if (tckRise) begin
      state_r <= tapNext(state_r, tmsLvl);
    end
  end

  // Instruction register
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !trstEffN || state_r == tpms_pkg::TLR) begin
      ir_r      <= `TPMS_IR_IDCODE;
      irShift_r <= `TPMS_IR_CAPTURE;
    end else if (tckRise) begin
      if (state_r == tpms_pkg::CAP_IR) begin
        irShift_r <= `TPMS_IR_CAPTURE;
      end else if (state_r == tpms_pkg::SH_IR) begin
        irShift_r <= {tdiLvl, irShift_r[`TPMS_IR_W-1:1]};
      end else if (state_r == tpms_pkg::UPD_IR) begin
        ir_r <= irShift_r;
      end
    end
  end

  // Data registers: identification or one-bit bypass
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !trstEffN) begin
      drShift_r <= '0;
    end else if (tckRise) begin
      if (state_r == tpms_pkg::CAP_DR) begin
        drShift_r <= (ir_r == `TPMS_IR_IDCODE) ? IDCODE : '0;
      end else if (state_r == tpms_pkg::SH_DR) begin
        if (ir_r == `TPMS_IR_IDCODE) begin
          drShift_r <= {tdiLvl, drShift_r[`TPMS_ID_W-1:1]};
        end else begin
          drShift_r <= {{(`TPMS_ID_W-1){1'b0}}, tdiLvl};
        end
      end
    end
  end

  // Output launch on falling test clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !trstEffN) begin
      tdo_r   <= 1'b0;
      tdoEn_r <= 1'b0;
    end else if (tckFall) begin
      tdo_r   <= (state_r == tpms_pkg::SH_IR) ? irShift_r[0] : drShift_r[0];
      tdoEn_r <= (state_r == tpms_pkg::SH_IR) || (state_r == tpms_pkg::SH_DR);
    end
  end

  // Mode and test enables
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      legacy_r <= 1'b1;
      testEn_r <= 1'b1;
    end else begin
      legacy_r <= strapLvl;
      testEn_r <= !(trstLvl && !strapLvl);
    end
  end

  assign testPortDataOut   = tdo_r;
  assign testPortDataOutEn = tdoEn_r;
  assign legacyMode        = legacy_r;
  assign globalTestPinEn   = testEn_r;
  assign testCtrlBitHiEn   = testEn_r;
  assign testCtrlBitLoEn   = testEn_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_legacy_mode_follow: assert property (
    legacyMode == $past(strapLvl))
    else $error("legacy mode does not follow strap");
  a_strap_pull_up: assert property (
    !framerModeSelectDrv [*6] |-> strapLvl)
    else $error("undriven strap did not read high");
  a_legacy_tap_reset: assert property (
    legacyMode && $past(strapLvl, 2) |-> state_r == tpms_pkg::TLR)
    else $error("test port not held reset in legacy mode");
  a_test_enable_table: assert property (
    (trstLvl && !strapLvl) [*2] |-> !globalTestPinEn && !testCtrlBitHiEn && !testCtrlBitLoEn)
    else $error("test enables on while reset high and strap low");
  a_test_enable_follow: assert property (
    globalTestPinEn == !$past(trstLvl && !strapLvl))
    else $error("global test enable does not follow reset and strap");
  a_reset_no_clock: assert property (
    !trstEffN |=> state_r == tpms_pkg::TLR && !testPortDataOutEn)
    else $error("test reset did not reset controller");
  a_reset_idcode_ir: assert property (
    $rose(trstEffN) |-> ##1 ir_r == `TPMS_IR_IDCODE)
    else $error("identification instruction not selected after reset");
  a_id_capture: assert property (
    tckRise && trstEffN && state_r == tpms_pkg::CAP_DR && ir_r == `TPMS_IR_IDCODE |=>
      drShift_r == IDCODE)
    else $error("identification value not captured");
  a_tms_step_rti: assert property (
    tckRise && trstEffN && state_r == tpms_pkg::TLR && !tmsLvl |=> state_r == tpms_pkg::RTI)
    else $error("controller did not step on low mode select");
  a_tms_step_sel: assert property (
    tckRise && trstEffN && state_r == tpms_pkg::RTI && tmsLvl |=> state_r == tpms_pkg::SEL_DR)
    else $error("controller did not step on high mode select");
  a_hold_no_edge: assert property (
    !tckRise && trstEffN && $past(trstEffN) |=> $stable(state_r))
    else $error("controller moved without rising test clock");
  a_ir_update: assert property (
    tckRise && trstEffN && state_r == tpms_pkg::UPD_IR |=> ir_r == $past(irShift_r))
    else $error("instruction not updated from shift stage");
  a_bypass_capture: assert property (
    tckRise && trstEffN && state_r == tpms_pkg::SH_DR && ir_r == `TPMS_IR_BYPASS |=>
      drShift_r[0] == $past(tdiLvl))
    else $error("data input not captured on rising edge");
  a_tdo_on_fall: assert property (
    $changed(testPortDataOut) |-> $past(tckFall) || $past(!trstEffN))
    else $error("data output changed away from falling edge");
  a_tdo_release: assert property (
    $rose(testPortDataOutEn) |-> $past(state_r == tpms_pkg::SH_DR || state_r == tpms_pkg::SH_IR))
    else $error("data output driven outside shift state");
  a_tdo_en_shift: assert property (
    tckFall && trstEffN |=>
      testPortDataOutEn == $past(state_r == tpms_pkg::SH_DR || state_r == tpms_pkg::SH_IR))
    else $error("data output enable does not match shift state");

  c_ir_update: cover property (tckRise && state_r == tpms_pkg::UPD_IR);
  c_id_shift:  cover property (tckFall && state_r == tpms_pkg::SH_DR && ir_r == `TPMS_IR_IDCODE);
  c_new_mode:  cover property ($fell(legacyMode));
  c_tdo_drive: cover property ($rose(testPortDataOutEn));
endmodule
`default_nettype wire

// ==== tb/tpms_jtag_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpms_jtag_host (
  // Clock
  input  wire logic ref_clk,
  // Pins towards the device
  output logic      framerModeSelect,
  output logic      framerModeSelectDrv,
  output logic      testPortClock,
  output logic      testPortModeSel,
  output logic      testPortModeSelDrv,
  output logic      testPortDataIn,
  output logic      testPortResetN,
  // Pins from the device
  input  wire logic testPortDataOut,
  input  wire logic testPortDataOutEn
);
  initial begin
    framerModeSelect    = 1'b0;
    framerModeSelectDrv = 1'b0;
    testPortClock       = 1'b0;
    testPortModeSel     = 1'b0;
    testPortModeSelDrv  = 1'b0;
    testPortDataIn      = 1'b0;
    testPortResetN      = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One 80 ns test clock period, pins set while low, output taken at the fall
  task automatic step(input logic tms, input logic drv, input logic tdi,
                      output logic tdo, output logic en);
    testPortModeSelDrv = drv;
    testPortModeSel    = drv ? tms : ~testPortModeSel;
    testPortDataIn     = tdi;
    wait_clk(4);
    testPortClock = 1'b1;
    wait_clk(4);
    tdo           = testPortDataOut;
    en            = testPortDataOutEn;
    testPortClock = 1'b0;
  endtask
  // Strap and test reset levels, then settle
  task automatic set_pins(input logic strap, input logic drv, input logic rstN);
    framerModeSelectDrv = drv;
    framerModeSelect    = drv ? strap : ~framerModeSelect;
    testPortResetN      = rstN;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_test_port_mode_select.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tpms_consts.svh"
module tb_test_port_mode_select;
  // Identification value, arbitrary
  localparam logic [`TPMS_ID_W-1:0] ID = 32'h0A5C_3E91;
  logic      ref_clk;
  logic      sys_rst;
  int        errCount;
  int        testsRun;
  wire logic strap, strapDrv, tClk, mSel, mSelDrv, dIn, rstN, dOut, dOutEn;
  wire logic legacy, gEn, hiEn, loEn;
  logic [31:0] q;
  logic        e;

  tpms_top #(.IDCODE(ID)) i_tpms_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .framerModeSelect(strap),
    .framerModeSelectDrv(strapDrv), .testPortClock(tClk), .testPortModeSel(mSel),
    .testPortModeSelDrv(mSelDrv), .testPortDataIn(dIn), .testPortResetN(rstN),
    .testPortDataOut(dOut), .testPortDataOutEn(dOutEn), .legacyMode(legacy),
    .globalTestPinEn(gEn), .testCtrlBitHiEn(hiEn), .testCtrlBitLoEn(loEn));
  tpms_jtag_host i_tpms_jtag_host (
    .ref_clk(ref_clk), .framerModeSelect(strap), .framerModeSelectDrv(strapDrv),
    .testPortClock(tClk), .testPortModeSel(mSel), .testPortModeSelDrv(mSelDrv),
    .testPortDataIn(dIn), .testPortResetN(rstN), .testPortDataOut(dOut),
    .testPortDataOutEn(dOutEn));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stopTest();
    $display("Comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Steps with mode select bits taken LSB first
  task automatic move(input int n, input logic [7:0] b, output logic en);
    logic o;
    for (int i = 0; i < n; i++) begin
      i_tpms_jtag_host.step(b[i], 1'b1, 1'b0, o, en);
    end
  endtask
  // Shift n bits, last one leaves the shift state
  task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q,
                       output logic enAll);
    logic o, en;
    q = '0;
    enAll = 1'b1;
    for (int i = 0; i < n; i++) begin
      i_tpms_jtag_host.step(i == n - 1, 1'b1, d[i], o, en);
      q[i]  = o;
      enAll = enAll & en;
    end
  endtask
  task automatic t_legacy();
    i_tpms_jtag_host.set_pins(1'b0, 1'b0, 1'b1);
    check(32'(legacy), 32'h0000_0001);
    check(32'({gEn, hiEn, loEn}), 32'h0000_0007);
    move(5, 8'h02, e);
    check(32'(e), 32'h0000_0000);
  endtask
  task automatic t_table();
    for (int i = 0; i < 4; i++) begin
      i_tpms_jtag_host.set_pins(i[0], 1'b1, i[1]);
      check(32'(legacy), 32'(i[0]));
      check(32'({gEn, hiEn, loEn}), (i == 2) ? 32'h0 : 32'h7);
    end
  endtask
  task automatic t_idcode();
    i_tpms_jtag_host.set_pins(1'b0, 1'b1, 1'b0);
    i_tpms_jtag_host.set_pins(1'b0, 1'b1, 1'b1);
    move(4, 8'h02, e);
    shift(32, 32'h0000_0000, q, e);
    check(q, ID);
    check(32'(e), 32'h0000_0001);
    move(2, 8'h01, e);
    check(32'(e), 32'h0000_0000);
  endtask
  task automatic t_bypass();
    move(4, 8'h03, e);
    shift(3, 32'h0000_0007, q, e);
    check(q, 32'(`TPMS_IR_CAPTURE));
    move(5, 8'h05, e);
    shift(4, 32'h0000_000B, q, e);
    check(q, 32'h0000_0006);
    for (int i = 0; i < 5; i++) begin
      i_tpms_jtag_host.step(1'b0, 1'b0, 1'b0, q[0], e);
    end
    move(4, 8'h02, e);
    shift(32, 32'h0000_0000, q, e);
    check(q, ID);
  endtask
  task automatic t_async();
    move(5, 8'h03, e);
    check(32'(e), 32'h0000_0001);
    i_tpms_jtag_host.set_pins(1'b0, 1'b1, 1'b0);
    check(32'(dOutEn), 32'h0000_0000);
    check(32'(gEn), 32'h0000_0001);
  endtask

  initial begin
    errCount = 0;
    testsRun = 0;
    sys_rst  = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_legacy();
    t_table();
    t_idcode();
    t_bypass();
    t_async();
    stopTest();
  end
  initial begin
    #100_000;
    errCount++;
    stopTest();
  end
endmodule
`default_nettype wire
